/* File: hw/core_status_sideband.sv */
// Purpose: Status sideband of a processor core with AHB-Lite register access
// Assumes: Single clock hclk; resets and interrupt pins are asynchronous
// Notes: Cold reset is hresetn; exception entry is modelled by commands
`default_nettype none
module core_status_sideband (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic warm_reset_in,
    input wire logic nmi_in,
    input wire logic [sideband_pkg::int_lines-1:0] int_req_in,
    output logic error_level_out,
    output logic exception_level_out,
    output logic reduced_power_out,
    output logic sleep_out,
    output logic irq_out
);
    localparam int ev = sideband_pkg::evt_width;
    localparam int nl = sideband_pkg::int_lines;

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    logic [nl+1:0] async_bundle;
    logic [nl+1:0] sync_bundle;
    logic [nl-1:0] int_sync;
    logic warm_sync;
    logic nmi_sync;
    logic warm_pulse;
    logic nmi_pulse;

    // All sideband pins active high
    assign async_bundle = {warm_reset_in, nmi_in, int_req_in};

    input_sync #(
        .width(nl + 2)
    ) sync_inst (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(async_bundle),
        .level_out(sync_bundle)
    );

    assign int_sync = sync_bundle[nl-1:0];
    assign nmi_sync = sync_bundle[nl];
    assign warm_sync = sync_bundle[nl+1];

    rise_detect nmi_edge_inst (
        .hclk(hclk),
        .hresetn(hresetn),
        .level_in(nmi_sync),
        .pulse_out(nmi_pulse)
    );

    // A held warm reset takes the exception once, at its leading edge
    rise_detect warm_edge_inst (
        .hclk(hclk),
        .hresetn(hresetn),
        .level_in(warm_sync),
        .pulse_out(warm_pulse)
    );

    // ------------------------------------------------------------
    // AHB-Lite slave front end
    // ------------------------------------------------------------
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic wr_pending_reg;
    logic [7:0] wr_addr_reg;
    logic addr_phase;
    logic take_write;
    logic [7:0] rd_addr;
    logic hreadyout_reg;
    logic hresp_reg;

    assign addr_phase = hsel & hready & (htrans == sideband_pkg::htrans_nonseq);
    // Only whole-word writes are honoured; narrower writes complete but store nothing
    assign take_write = addr_phase & hwrite & (hsize == sideband_pkg::hsize_word);
    assign rd_addr = haddr[7:0];

    // ------------------------------------------------------------
    // Core state
    // ------------------------------------------------------------
    logic [31:0] status_reg;
    logic [31:0] status_next;
    logic [ev-1:0] event_reg;
    logic [ev-1:0] event_next;
    logic [ev-1:0] mask_reg;
    logic [ev-1:0] event_set;
    logic irq_reg;
    sideband_pkg::run_type run_reg;
    sideband_pkg::run_type run_next;

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    logic wr_status;
    logic wr_command;
    logic wr_event;
    logic wr_mask;

    assign wr_status = wr_pending_reg & (wr_addr_reg == sideband_pkg::status_off);
    assign wr_command = wr_pending_reg & (wr_addr_reg == sideband_pkg::command_off);
    assign wr_event = wr_pending_reg & (wr_addr_reg == sideband_pkg::event_off);
    assign wr_mask = wr_pending_reg & (wr_addr_reg == sideband_pkg::mask_off);

    // ------------------------------------------------------------
    // Exception decisions
    // ------------------------------------------------------------
    logic asleep;
    logic [nl-1:0] int_enabled;
    logic int_wake;
    logic int_take;
    logic cmd_exc;
    logic cmd_ret;
    logic cmd_wait;
    logic cmd_dbg;
    logic high_exc;

    assign asleep = (run_reg == sideband_pkg::sleep_state);
    assign int_enabled = int_sync & status_reg[sideband_pkg::im_hi:sideband_pkg::im_lo];
    assign int_wake = |int_enabled;
    assign int_take = int_wake & status_reg[sideband_pkg::ie_pos]
                      & ~status_reg[sideband_pkg::exl_pos] & ~status_reg[sideband_pkg::erl_pos]
                      & ~asleep;
    assign high_exc = warm_pulse | nmi_pulse;

    // Commands are refused while asleep: the core clock is stopped
    assign cmd_exc = wr_command & ~asleep & hwdata[sideband_pkg::cmd_exc_pos];
    assign cmd_ret = wr_command & ~asleep & hwdata[sideband_pkg::cmd_ret_pos];
    assign cmd_wait = wr_command & ~asleep & hwdata[sideband_pkg::cmd_wait_pos];
    assign cmd_dbg = wr_command & ~asleep & hwdata[sideband_pkg::cmd_dbg_pos];

    // ------------------------------------------------------------
    // Status register next value
    // ------------------------------------------------------------
    // Hardware exception entry outranks software writes in the same cycle
    always_comb begin
        status_next = status_reg;
        if (wr_status && !asleep) begin
            status_next = (status_reg & ~sideband_pkg::status_writable)
                          | (hwdata & sideband_pkg::status_writable);
        end
        if (cmd_ret) begin
            if (status_reg[sideband_pkg::erl_pos]) begin
                status_next[sideband_pkg::erl_pos] = 1'b0;
            end else begin
                status_next[sideband_pkg::exl_pos] = 1'b0;
            end
        end
        if (int_take || cmd_exc) begin
            status_next[sideband_pkg::exl_pos] = 1'b1;
        end
        if (high_exc) begin
            status_next[sideband_pkg::erl_pos] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Sleep state machine
    // ------------------------------------------------------------
    always_comb begin
        run_next = run_reg;
        case (run_reg)
            sideband_pkg::run_state: begin
                if (cmd_wait && !high_exc && !int_take) begin
                    run_next = sideband_pkg::sleep_state;
                end
            end
            sideband_pkg::sleep_state: begin
                if (int_wake || high_exc) begin
                    run_next = sideband_pkg::run_state;
                end
            end
            default: begin
                run_next = sideband_pkg::run_state;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Event flags: set wins over write-one-to-clear
    // ------------------------------------------------------------
    always_comb begin
        event_set = '0;
        event_set[sideband_pkg::evt_soft_pos] = warm_pulse;
        event_set[sideband_pkg::evt_nmi_pos] = nmi_pulse;
        event_set[sideband_pkg::evt_int_pos] = int_take;
        event_set[sideband_pkg::evt_wake_pos] = asleep & (run_next == sideband_pkg::run_state);
        // Debug entry is recorded but leaves the exception level alone
        event_set[sideband_pkg::evt_dbg_pos] = cmd_dbg;
        event_next = event_reg;
        if (wr_event) begin
            event_next = event_reg & ~hwdata[ev-1:0];
        end
        event_next = event_next | event_set;
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [31:0] state_word;
    logic [31:0] event_word;
    logic [31:0] mask_word;

    assign state_word = {{(31 - sideband_pkg::state_sleep_pos){1'b0}}, asleep,
                         {(sideband_pkg::state_sleep_pos - nl){1'b0}}, int_sync};
    assign event_word = {{(32 - ev){1'b0}}, event_reg};
    assign mask_word = {{(32 - ev){1'b0}}, mask_reg};

    always_comb begin
        hrdata_next = hrdata_reg;
        if (addr_phase && !hwrite) begin
            if (rd_addr == sideband_pkg::status_off) begin
                hrdata_next = status_reg;
            end else if (rd_addr == sideband_pkg::state_off) begin
                hrdata_next = state_word;
            end else if (rd_addr == sideband_pkg::event_off) begin
                hrdata_next = event_word;
            end else if (rd_addr == sideband_pkg::mask_off) begin
                hrdata_next = mask_word;
            end else begin
                hrdata_next = 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_reg <= 32'h0000_0000;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end else begin
            wr_pending_reg <= take_write;
            wr_addr_reg <= rd_addr;
            hrdata_reg <= hrdata_next;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_reg <= sideband_pkg::status_reset;
            run_reg <= sideband_pkg::run_state;
            event_reg <= '0;
            mask_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            run_reg <= run_next;
            event_reg <= event_next;
            if (wr_mask) begin
                mask_reg <= hwdata[ev-1:0];
            end
            irq_reg <= |(event_next & mask_reg);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign error_level_out = status_reg[sideband_pkg::erl_pos];
    assign exception_level_out = status_reg[sideband_pkg::exl_pos];
    assign reduced_power_out = status_reg[sideband_pkg::rp_pos];
    assign sleep_out = asleep;
    assign irq_out = irq_reg;
    assign hrdata = hrdata_reg;
    // Zero wait states and OKAY only, still registered so every output leaves a flop
    assign hreadyout = hreadyout_reg;
    assign hresp = hresp_reg;
endmodule
`default_nettype wire

/* File: include/sideband_pkg.sv */
// Purpose: Constants shared by the core status sideband block
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes: Register offsets are byte addresses
`default_nettype none
package sideband_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] status_off = 8'h00;
    localparam logic [7:0] command_off = 8'h04;
    localparam logic [7:0] state_off = 8'h08;
    localparam logic [7:0] event_off = 8'h0C;
    localparam logic [7:0] mask_off = 8'h10;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int ie_pos = 0;
    localparam int exl_pos = 1;
    localparam int erl_pos = 2;
    localparam int im_lo = 10;
    localparam int im_hi = 15;
    localparam int rp_pos = 27;
    // Cold reset leaves the error level set
    localparam logic [31:0] status_reset = 32'h0000_0004;
    localparam logic [31:0] status_writable = 32'h0800_FC07;

    // ------------------------------------------------------------
    // Command register bits
    // ------------------------------------------------------------
    localparam int cmd_exc_pos = 0;
    localparam int cmd_ret_pos = 1;
    localparam int cmd_wait_pos = 2;
    localparam int cmd_dbg_pos = 3;

    // ------------------------------------------------------------
    // State register fields
    // ------------------------------------------------------------
    localparam int state_int_lo = 0;
    localparam int state_sleep_pos = 8;

    // ------------------------------------------------------------
    // Event bits (status and mask share the layout)
    // ------------------------------------------------------------
    localparam int evt_soft_pos = 0;
    localparam int evt_nmi_pos = 1;
    localparam int evt_int_pos = 2;
    localparam int evt_wake_pos = 3;
    localparam int evt_dbg_pos = 4;
    localparam int evt_width = 5;

    localparam logic [1:0] htrans_nonseq = 2'h2;
    localparam logic [2:0] hsize_word = 3'h2;
    localparam int int_lines = 6;

    typedef enum logic {run_state, sleep_state} run_type;
endpackage
`default_nettype wire

/* File: hw/input_sync.sv */
// Purpose: Three-flop synchroniser for asynchronous level inputs
// Assumes: Inputs may change at any time relative to hclk
// Notes: A bit changes only once the second and third stages agree
`default_nettype none
module input_sync #(
    parameter int width = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] level_out
);
    logic [width-1:0] stage1_reg;
    logic [width-1:0] stage2_reg;
    logic [width-1:0] stage3_reg;
    logic [width-1:0] level_reg;
    logic [width-1:0] agree;

    // Refused at elaboration: a zero-width bundle has nothing to synchronise
    if (width < 1) begin : g_width_check
        $error("input_sync width must be at least 1");
    end

    // Stage one feeds stage two only
    assign agree = ~(stage2_reg ^ stage3_reg);
    assign level_out = level_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
            level_reg <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            level_reg <= (agree & stage3_reg) | (~agree & level_reg);
        end
    end
endmodule
`default_nettype wire

/* File: hw/rise_detect.sv */
// Purpose: One-cycle pulse on each low-to-high change of a synchronised level
// Assumes: Input is already in the hclk domain
// Notes: A level held high yields a single pulse
`default_nettype none
module rise_detect (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic level_in,
    output logic pulse_out
);
    logic prev_reg;

    assign pulse_out = level_in & ~prev_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= level_in;
        end
    end
endmodule
`default_nettype wire

/* File: verif/sideband_chk.sv */
// Purpose: Port-level assertions for the core status sideband
// Assumes: Zero-wait bus, pins pass a three-flop synchroniser
// Notes: Writes are tracked one cycle into their data phase
`default_nettype none
module sideband_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic warm_reset_in,
    input wire logic nmi_in,
    input wire logic [sideband_pkg::int_lines-1:0] int_req_in,
    input wire logic error_level_out,
    input wire logic exception_level_out,
    input wire logic reduced_power_out,
    input wire logic sleep_out
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic wr_d;
    logic [3:0] act_cnt;
    wire pin_act = nmi_in || warm_reset_in || (|int_req_in);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_d <= 1'b0;
            act_cnt <= 4'hF;
        end else begin
            wr_d <= hsel && hready && htrans == sideband_pkg::htrans_nonseq && hwrite;
            act_cnt <= pin_act ? 4'h0 : (act_cnt == 4'hF ? act_cnt : act_cnt + 4'h1);
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_bus_ok; hreadyout && !hresp; endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready or not okay");
    property p_nmi_erl; $rose(nmi_in) ##1 nmi_in [*5] |-> ##[0:3] error_level_out; endproperty
    a_nmi_erl: assert property (p_nmi_erl) else $error("error level not raised by nmi");
    property p_warm_erl; $rose(warm_reset_in) ##1 warm_reset_in [*5] |-> ##[0:3] error_level_out; endproperty
    a_warm_erl: assert property (p_warm_erl) else $error("error level not raised by warm reset");
    property p_erl_fall; $fell(error_level_out) |-> $past(wr_d); endproperty
    a_erl_fall: assert property (p_erl_fall) else $error("error level fell without a write");
    property p_exl_fall; $fell(exception_level_out) |-> $past(wr_d); endproperty
    a_exl_fall: assert property (p_exl_fall) else $error("exception level fell without a write");
    property p_rp_chg; $changed(reduced_power_out) |-> $past(wr_d); endproperty
    a_rp_chg: assert property (p_rp_chg) else $error("reduced power moved without a write");
    property p_sleep_rise; $rose(sleep_out) |-> $past(wr_d); endproperty
    a_sleep_rise: assert property (p_sleep_rise) else $error("sleep without a wait command");
    property p_sleep_wake; $fell(sleep_out) |-> act_cnt < 4'hA; endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("woke with no pin activity");
    property p_exl_rise; $rose(exception_level_out) |-> $past(wr_d) || $past(|int_req_in, 3); endproperty
    a_exl_rise: assert property (p_exl_rise) else $error("exception level rose too early");
endmodule
bind core_status_sideband sideband_chk i_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .warm_reset_in, .nmi_in, .int_req_in, .error_level_out,
    .exception_level_out, .reduced_power_out, .sleep_out);
`default_nettype wire

/* File: verif/sideband_partner.sv */
// Purpose: System logic that raises resets and interrupt lines
// Assumes: Pins change just after a rising edge
// Notes: Levels are held until the bench asks for a change
`default_nettype none
module sideband_partner (
    input wire logic hclk,
    output logic warm_reset_in,
    output logic nmi_in,
    output logic [sideband_pkg::int_lines-1:0] int_req_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Pin drivers, all active high
    // ----------------------------------------
    initial begin
        warm_reset_in = 1'b0;
        nmi_in = 1'b0;
        int_req_in = '0;
    end
    // Must return low before the next request, else no new edge is seen
    task automatic set_nmi(input logic v);
        @(posedge hclk);
        nmi_in <= v;
    endtask
    task automatic set_warm(input logic v);
        @(posedge hclk);
        warm_reset_in <= v;
    endtask
    task automatic set_int(input logic [sideband_pkg::int_lines-1:0] v);
        @(posedge hclk);
        int_req_in <= v;
    endtask
endmodule
`default_nettype wire

/* File: verif/core_status_sideband_tb.sv */
// Purpose: Register and pin level tests of the core status sideband
// Assumes: Zero-wait slave, hready tied to hreadyout
// Notes: Outputs are sampled one edge after a write lands
`default_nettype none
module core_status_sideband_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, bus_size;
    logic warm_reset_in, nmi_in;
    logic [sideband_pkg::int_lines-1:0] int_req_in;
    logic error_level_out, exception_level_out, reduced_power_out, sleep_out, irq_out;
    int miscompares, checks_done;
    core_status_sideband i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .warm_reset_in, .nmi_in, .int_req_in,
        .error_level_out, .exception_level_out, .reduced_power_out, .sleep_out, .irq_out);
    sideband_partner i_partner (.hclk, .warm_reset_in, .nmi_in, .int_req_in);
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= 32'(a);
        hwrite <= w;
        htrans <= sideband_pkg::htrans_nonseq;
        hsize <= bus_size;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask
    // Order: error level, exception level, reduced power, sleep, irq
    task automatic outs(input logic [4:0] e);
        check({error_level_out, exception_level_out, reduced_power_out, sleep_out, irq_out}, e);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog, tests
    // ----------------------------------------
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    initial begin
        tick(5000);
        miscompares++;
        report_and_stop();
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        bus_size = sideband_pkg::hsize_word;
        hwdata = '0;
        miscompares = 0;
        checks_done = 0;
        tick(10);
        hresetn <= 1'b1;
        rchk(sideband_pkg::status_off, sideband_pkg::status_reset);
        outs(5'h10);
        rchk(sideband_pkg::mask_off, 32'h0000_0000);
        bus(1'b1, sideband_pkg::status_off, 32'hFFFF_FFFF);
        tick(1);
        outs(5'h1C);
        rchk(sideband_pkg::status_off, sideband_pkg::status_writable);
        bus(1'b1, sideband_pkg::status_off, 32'h0000_0000);
        tick(1);
        outs(5'h00);
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        rchk(8'h20, 32'h0000_0000);
        // A byte-wide write completes but must store nothing
        bus_size = 3'h0;
        bus(1'b1, sideband_pkg::status_off, 32'hFFFF_FFFF);
        bus_size = sideband_pkg::hsize_word;
        rchk(sideband_pkg::status_off, 32'h0000_0000);
        outs(5'h00);
        $display("test status done");
        bus(1'b1, sideband_pkg::command_off, 32'h0000_0001);
        tick(1);
        outs(5'h08);
        bus(1'b1, sideband_pkg::command_off, 32'h0000_0008);
        tick(1);
        outs(5'h08);
        rchk(sideband_pkg::event_off, 32'h0000_0010);
        bus(1'b1, sideband_pkg::command_off, 32'h0000_0002);
        tick(1);
        outs(5'h00);
        bus(1'b1, sideband_pkg::event_off, 32'h0000_001F);
        rchk(sideband_pkg::event_off, 32'h0000_0000);
        $display("test commands done");
        bus(1'b1, sideband_pkg::mask_off, 32'h0000_001F);
        i_partner.set_nmi(1'b1);
        tick(8);
        outs(5'h11);
        bus(1'b1, sideband_pkg::event_off, 32'h0000_0002);
        tick(8);
        outs(5'h10);
        rchk(sideband_pkg::event_off, 32'h0000_0000);
        i_partner.set_nmi(1'b0);
        bus(1'b1, sideband_pkg::command_off, 32'h0000_0002);
        bus(1'b1, sideband_pkg::mask_off, 32'h0000_0000);
        i_partner.set_warm(1'b1);
        tick(8);
        outs(5'h10);
        rchk(sideband_pkg::event_off, 32'h0000_0001);
        bus(1'b1, sideband_pkg::mask_off, 32'h0000_0001);
        tick(2);
        outs(5'h11);
        i_partner.set_warm(1'b0);
        bus(1'b1, sideband_pkg::event_off, 32'h0000_0001);
        bus(1'b1, sideband_pkg::command_off, 32'h0000_0002);
        tick(2);
        outs(5'h00);
        $display("test resets done");
        bus(1'b1, sideband_pkg::status_off, 32'h0000_FC01);
        for (int n = 0; n < sideband_pkg::int_lines; n++) begin
            i_partner.set_int(6'(1 << n));
            tick(2);
            outs(5'h00);
            tick(8);
            outs(5'h08);
            rchk(sideband_pkg::state_off, 32'(1 << n));
            i_partner.set_int(6'h00);
            tick(6);
            bus(1'b1, sideband_pkg::command_off, 32'h0000_0002);
        end
        rchk(sideband_pkg::event_off, 32'h0000_0004);
        bus(1'b1, sideband_pkg::event_off, 32'h0000_001F);
        $display("test interrupts done");
        bus(1'b1, sideband_pkg::status_off, 32'h0000_0400);
        bus(1'b1, sideband_pkg::command_off, 32'h0000_0004);
        tick(1);
        outs(5'h02);
        rchk(sideband_pkg::state_off, 32'h0000_0100);
        bus(1'b1, sideband_pkg::status_off, 32'h0800_0000);
        i_partner.set_int(6'h02);
        tick(20);
        outs(5'h02);
        i_partner.set_int(6'h01);
        tick(10);
        outs(5'h00);
        rchk(sideband_pkg::event_off, 32'h0000_0008);
        i_partner.set_int(6'h00);
        $display("test sleep done");
        @(posedge hclk);
        hresetn <= 1'b0;
        tick(2);
        hresetn <= 1'b1;
        tick(1);
        outs(5'h10);
        $display("test reset again done");
        report_and_stop();
    end
endmodule
`default_nettype wire
